// ==== rtl/effective_address_decode.sv ====
`timescale 1ns/1ps
`include "ead_consts.svh"
// Overview of operation
// RULE_01: mode 000 data reg, 001 address reg, 111/100 immediate operand.
// RULE_02: modes 010-101 address indirect, postinc, predec, 16-bit displacement.
// RULE_03: mode 110 address is address reg plus index plus sign-extended d8.
// RULE_04: 111/010 is pc plus d16 and never alterable.
// RULE_05: 111/011 is pc plus index plus d8 and never alterable.
// RULE_06: 111/000 short absolute, 111/001 long absolute from extension.
// RULE_07: exception entry pushes status word then sets supervisor flag.
// RULE_08: user return via supervisor status write or return op flushes fetch.
// RULE_09: sixteen 32-bit general registers, any usable as index.
// RULE_10: five control registers reachable only in supervisor mode.
// RULE_11: user mode touches only the low status byte.
// RULE_12: vector base keeps upper 12 bits, lower 20 read zero.
// RULE_13: pc holds address of instruction being executed.
// RULE_14: cache control enables cache, two windows mark noncacheable regions; the code only stores and reads back ncw0/ncw1, with no effect.
// RULE_15: two's complement arithmetic on signed or unsigned operands.
// RULE_16: operand size bit, byte, word, long from encoding or operation.
// RULE_17: index value is scaled before adding base and displacement.
// RULE_18: removed instruction groups rejected; multiply-accumulate group decoded.
// RULE_19: undefined 111 register fields or disallowed modes raise illegal.
// RULE_20: privilege flag shows mode; flag-altering ops and stop supervisor only.
module effective_address_decode
    import ead_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic [31:0] instr_ext,
    input wire logic [31:0] instr_pc,
    output logic instr_ready,
    input wire logic exc_entry,
    output logic supervisor,
    output logic fetch_flush,
    output logic illegal_exc,
    output logic priv_exc,
    output logic mac_op,
    output logic cache_enable,
    output logic [31:0] ea_addr,
    output logic [3:0] ea_class,
    output logic [1:0] op_size,
    output logic ea_alterable
);
    typedef struct packed {
        dec_state_e st;
        logic [15:0][31:0] gpr;
        logic [15:0] sw;
        logic [15:0] stacked;
        logic [11:0] vtb;
        word_t cache;
        word_t ncw0;
        word_t ncw1;
        word_t pc;
        logic [15:0] op;
        word_t ext;
        word_t ea;
        ea_class_e cls;
        op_size_e sz;
        logic alt;
        logic illegal;
        logic priv;
        logic mac;
        logic flush;
        word_t rdata;
    } state_s;

    state_s r;
    state_s n;

    logic setup;
    logic access;
    logic is_gpr;
    logic sup_only;
    logic deny;
    logic [3:0] gidx;

    ////////////////////////////////////////////////////////////////////////
    // apb decode
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign is_gpr = (paddr[7:6] == 2'b01) && (paddr[1:0] == 2'b00);
    assign gidx = paddr[5:2];
    always_comb begin
        case (paddr)
            `OFS_VTB, `OFS_CACHE, `OFS_NCW0, `OFS_NCW1, `OFS_STACKED: sup_only = 1'b1;
            default: sup_only = 1'b0;
        endcase
    end
    assign deny = sup_only && !r.sw[`SW_S_BIT]; // [RULE_10]
    assign pready = 1'b1;
    assign pslverr = access && deny;

    ////////////////////////////////////////////////////////////////////////
    // result word and qualifiers
    word_t result_word;
    logic wr_ok;
    logic ret_ok;

    always_comb begin
        result_word = 32'h0000_0000;
        result_word[3:0] = r.cls;
        result_word[5:4] = r.sz;
        result_word[8] = r.alt;
        result_word[9] = r.illegal;
        result_word[10] = r.priv;
        result_word[11] = r.mac;
    end

    assign wr_ok = access && pwrite && !deny;
    assign ret_ok = (r.op == 16'h4E73) && r.sw[`SW_S_BIT] && !r.illegal;

    ////////////////////////////////////////////////////////////////////////
    // decode helpers
    function automatic logic removed_op(input logic [15:0] op, input logic [31:0] ext);
        logic bcd;
        logic rot;
        logic dbcc;
        logic mul64;
        bcd = (op[15:12] == 4'hC || op[15:12] == 4'h8) && op[8] && (op[7:4] == 4'h0);
        rot = (op[15:12] == 4'hE) && (op[4:3] == 2'b11 || op[7:6] == 2'b11);
        dbcc = (op[15:12] == 4'h5) && (op[7:3] == 5'b11001);
        mul64 = (op[15:6] == 10'b0100110000) && ext[26];
        removed_op = bcd || rot || dbcc || mul64; // [RULE_18]
    endfunction

    function automatic logic priv_op(input logic [15:0] op);
        logic to_sw;
        logic stop_op;
        logic ret_op;
        logic or_sw;
        to_sw = (op[15:6] == 10'b0100011011);
        stop_op = (op == 16'h4E72);
        ret_op = (op == 16'h4E73);
        or_sw = (op == 16'h007C);
        priv_op = to_sw || stop_op || ret_op || or_sw; // [RULE_20]
    endfunction

    function automatic op_size_e size_of(input logic [15:0] op);
        if (op[15:12] == 4'h0 && (op[8] || op[11:8] == 4'h8)) begin
            size_of = SZ_BIT; // [RULE_16]
        end else begin
            case (op[7:6])
                2'b00: size_of = SZ_BYTE;
                2'b01: size_of = SZ_WORD;
                default: size_of = SZ_LONG;
            endcase
        end
    endfunction

    function automatic word_t step_of(input op_size_e sz);
        case (sz)
            SZ_WORD: step_of = 32'h0000_0002;
            SZ_LONG: step_of = 32'h0000_0004;
            default: step_of = 32'h0000_0001;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // next state
    logic [2:0] mode;
    logic [2:0] rfld;
    logic [3:0] areg;
    word_t base;
    word_t idx_val;
    word_t idx_scaled;
    word_t d8;
    word_t d16;
    word_t step;

    always_comb begin
        n = r;
        n.flush = 1'b0;
        mode = r.op[5:3];
        rfld = r.op[2:0];
        areg = {1'b1, rfld};
        base = r.gpr[areg];
        idx_val = r.gpr[r.ext[15:12]]; // [RULE_09]
        if (!r.ext[11]) begin
            idx_val = {{16{idx_val[15]}}, idx_val[15:0]};
        end
        idx_scaled = idx_val << r.ext[10:9]; // [RULE_17]
        d8 = {{24{r.ext[7]}}, r.ext[7:0]}; // [RULE_15]
        d16 = {{16{r.ext[15]}}, r.ext[15:0]};
        step = step_of(r.sz);

        // register reads sampled in setup, answered in access
        if (setup) begin
            n.rdata = 32'h0000_0000;
            if (is_gpr) begin
                n.rdata = r.gpr[gidx];
            end else if (!deny) begin
                case (paddr)
                    `OFS_OPWORD: n.rdata = {16'h0000, r.op};
                    `OFS_RESULT: n.rdata = result_word;
                    `OFS_EA: n.rdata = r.ea;
                    `OFS_PC: n.rdata = r.pc;
                    `OFS_SW: n.rdata = r.sw[`SW_S_BIT] ? {16'h0000, r.sw}
                        : {24'h000000, r.sw[7:0]}; // [RULE_11]
                    `OFS_VTB: n.rdata = {r.vtb, 20'h00000}; // [RULE_12]
                    `OFS_CACHE: n.rdata = r.cache;
                    `OFS_NCW0: n.rdata = r.ncw0;
                    `OFS_NCW1: n.rdata = r.ncw1;
                    `OFS_STACKED: n.rdata = {16'h0000, r.stacked};
                    default: n.rdata = 32'h0000_0000;
                endcase
            end
        end

        // register writes at the access edge
        if (wr_ok) begin
            if (is_gpr) begin
                n.gpr[gidx] = pwdata;
            end else begin
                case (paddr)
                    `OFS_SW: begin
                        if (r.sw[`SW_S_BIT]) begin
                            n.sw = pwdata[15:0];
                            n.flush = !pwdata[`SW_S_BIT]; // [RULE_08]
                        end else begin
                            n.sw[7:0] = pwdata[7:0]; // [RULE_11]
                        end
                    end
                    `OFS_VTB: n.vtb = pwdata[31:20]; // [RULE_12]
                    `OFS_CACHE: n.cache = pwdata; // [RULE_14]
                    `OFS_NCW0: n.ncw0 = pwdata; // [RULE_14]
                    `OFS_NCW1: n.ncw1 = pwdata; // [RULE_14]
                    default: n.rdata = n.rdata;
                endcase
            end
        end

        // decode sequence
        case (r.st)
            ST_IDLE: begin
                if (instr_valid) begin
                    n.op = instr_word;
                    n.ext = instr_ext;
                    n.pc = instr_pc; // [RULE_13]
                    n.sz = size_of(instr_word);
                    n.st = ST_EA;
                end
            end
            ST_EA: begin
                n.alt = 1'b1;
                n.ea = 32'h0000_0000;
                n.illegal = removed_op(r.op, r.ext);
                n.mac = (r.op[15:12] == 4'hA); // [RULE_18]
                n.priv = priv_op(r.op) && !r.sw[`SW_S_BIT]; // [RULE_20]
                case (mode)
                    3'b000: begin
                        n.cls = EA_DREG; // [RULE_01]
                        n.ea = {29'h0, rfld};
                    end
                    3'b001: begin
                        n.cls = EA_AREG; // [RULE_01]
                        n.ea = {28'h0, areg};
                    end
                    3'b010: begin
                        n.cls = EA_IND; // [RULE_02]
                        n.ea = base;
                    end
                    3'b011: begin
                        n.cls = EA_POSTINC; // [RULE_02]
                        n.ea = base;
                        n.gpr[areg] = base + step;
                    end
                    3'b100: begin
                        n.cls = EA_PREDEC; // [RULE_02]
                        n.ea = base - step;
                        n.gpr[areg] = base - step;
                    end
                    3'b101: begin
                        n.cls = EA_DISP16; // [RULE_02]
                        n.ea = base + d16;
                    end
                    3'b110: begin
                        n.cls = EA_INDEX; // [RULE_03]
                        n.ea = base + idx_scaled + d8;
                    end
                    default: begin
                        case (rfld)
                            3'b000: begin
                                n.cls = EA_ABS_W; // [RULE_06]
                                n.ea = d16;
                            end
                            3'b001: begin
                                n.cls = EA_ABS_L; // [RULE_06]
                                n.ea = r.ext;
                            end
                            3'b010: begin
                                n.cls = EA_PC_DISP; // [RULE_04]
                                n.ea = r.pc + 32'h0000_0002 + d16;
                                n.alt = 1'b0;
                            end
                            3'b011: begin
                                n.cls = EA_PC_INDEX; // [RULE_05]
                                n.ea = r.pc + 32'h0000_0002 + idx_scaled + d8;
                                n.alt = 1'b0;
                            end
                            3'b100: begin
                                n.cls = EA_IMM; // [RULE_01]
                                n.ea = r.ext;
                                n.alt = 1'b0;
                            end
                            default: begin
                                n.cls = EA_NONE;
                                n.alt = 1'b0;
                                n.illegal = 1'b1; // [RULE_19]
                            end
                        endcase
                    end
                endcase
                if (r.sz == SZ_BIT && mode == 3'b001) begin
                    n.illegal = 1'b1; // [RULE_19]
                end
                n.st = ST_WB;
            end
            ST_WB: begin
                if (ret_ok) begin
                    n.sw = r.stacked;
                    n.gpr[15] = r.gpr[15] + `STACK_STEP;
                    n.flush = 1'b1; // [RULE_08]
                end
                n.st = ST_IDLE;
            end
            default: n.st = ST_IDLE;
        endcase

        // exception entry wins over everything else on the status word
        if (exc_entry) begin
            n.stacked = n.sw; // [RULE_07]
            n.gpr[15] = n.gpr[15] - `STACK_STEP;
            n.sw[`SW_S_BIT] = 1'b1; // [RULE_07]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.st <= ST_IDLE;
            r.sw <= `SW_RST;
            r.cls <= EA_NONE;
            r.sz <= SZ_LONG;
        end else begin
            r <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign prdata = r.rdata;
    assign instr_ready = (r.st == ST_IDLE);
    assign supervisor = r.sw[`SW_S_BIT]; // [RULE_20]
    assign fetch_flush = r.flush;
    assign illegal_exc = r.illegal;
    assign priv_exc = r.priv;
    assign mac_op = r.mac;
    assign cache_enable = r.cache[`CACHE_EN_BIT]; // [RULE_14]
    assign ea_addr = r.ea;
    assign ea_class = r.cls;
    assign op_size = r.sz;
    assign ea_alterable = r.alt;
endmodule

// ==== rtl/ead_consts.svh ====
`ifndef EAD_CONSTS_SVH
`define EAD_CONSTS_SVH
// register byte offsets
`define OFS_OPWORD 8'h00
`define OFS_RESULT 8'h04
`define OFS_EA 8'h08
`define OFS_PC 8'h0C
`define OFS_SW 8'h10
`define OFS_VTB 8'h14
`define OFS_CACHE 8'h18
`define OFS_NCW0 8'h1C
`define OFS_NCW1 8'h20
`define OFS_STACKED 8'h24
`define OFS_GPR 8'h40
// field positions
`define SW_S_BIT 13
`define CACHE_EN_BIT 31
`define VTB_KEEP 12
// reset value and stack step
`define SW_RST 16'h2700
`define STACK_STEP 32'h0000_0004
`endif

// ==== rtl/ead_pkg.sv ====
package ead_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EA = 2'b01,
        ST_WB = 2'b11
    } dec_state_e;
    typedef enum logic [3:0] {
        EA_DREG = 4'h0,
        EA_AREG = 4'h1,
        EA_IND = 4'h2,
        EA_POSTINC = 4'h3,
        EA_PREDEC = 4'h4,
        EA_DISP16 = 4'h5,
        EA_INDEX = 4'h6,
        EA_ABS_W = 4'h7,
        EA_ABS_L = 4'h8,
        EA_PC_DISP = 4'h9,
        EA_PC_INDEX = 4'hA,
        EA_IMM = 4'hB,
        EA_NONE = 4'hF
    } ea_class_e;
    typedef enum logic [1:0] {
        SZ_BIT = 2'b00,
        SZ_BYTE = 2'b01,
        SZ_WORD = 2'b10,
        SZ_LONG = 2'b11
    } op_size_e;
    typedef logic [31:0] word_t;
endpackage

// ==== testbench/ead_checker.sv ====
`timescale 1ns/1ps
module ead_checker
    import ead_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input logic pslverr,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input logic instr_ready,
    input wire logic exc_entry,
    input logic supervisor,
    input logic fetch_flush,
    input logic illegal_exc,
    input logic priv_exc,
    input logic mac_op,
    input logic cache_enable,
    input logic [3:0] ea_class,
    input logic ea_alterable
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire take = instr_valid && instr_ready;
    wire acc = psel && penable;
    sequence s_busy;
        !instr_ready ##1 !instr_ready ##1 instr_ready;
    endsequence
    sequence s_user_ctl;
        acc && !supervisor && paddr inside {8'h14, 8'h18, 8'h1C, 8'h20, 8'h24};
    endsequence
    AST_DECODE_SLOT: assert property (take |=> s_busy)
        else $error("decode slot timing wrong");
    AST_EXC_SUPER: assert property (exc_entry |=> supervisor)
        else $error("exception entry left user mode");
    AST_SUPER_RISE: assert property ($rose(supervisor) |-> $past(exc_entry))
        else $error("supervisor set without exception");
    AST_FALL_FLUSH: assert property ($fell(supervisor) |-> ##[0:2] fetch_flush)
        else $error("user return without flush");
    AST_FLUSH_PULSE: assert property (fetch_flush |=> !fetch_flush)
        else $error("flush longer than one cycle");
    AST_USER_DENY: assert property (s_user_ctl |-> pslverr)
        else $error("user reached control register");
    AST_SUPER_GRANT: assert property (acc && supervisor |-> !pslverr)
        else $error("supervisor access refused");
    AST_PC_DISP: assert property (ea_class == EA_PC_DISP |-> !ea_alterable)
        else $error("pc displacement alterable");
    AST_PC_INDEX: assert property (ea_class == EA_PC_INDEX |-> !ea_alterable)
        else $error("pc index alterable");
    AST_BAD_MODE: assert property (take && instr_word[15:6] == 10'h003
        && instr_word[5:0] inside {6'h3D, 6'h3E, 6'h3F} |-> ##3 illegal_exc)
        else $error("undefined mode accepted");
    AST_MAC: assert property (take && instr_word[15:12] == 4'hA |-> ##3 mac_op)
        else $error("mac op not flagged");
    AST_STOP_USER: assert property (take && instr_word == 16'h4E72 && !supervisor
        |-> ##3 priv_exc)
        else $error("stop allowed in user mode");
    AST_CACHE: assert property (acc && pwrite && supervisor && paddr == 8'h18
        |=> cache_enable == $past(pwdata[31]))
        else $error("cache enable not written");
endmodule
bind effective_address_decode ead_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pslverr, .instr_valid, .instr_word, .instr_ready, .exc_entry,
    .supervisor, .fetch_flush, .illegal_exc, .priv_exc, .mac_op, .cache_enable, .ea_class,
    .ea_alterable);

// ==== testbench/tb_effective_address_decode.sv ====
`timescale 1ns/1ps
module tb_effective_address_decode;
    import ead_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, instr_valid = 0;
    logic exc_entry = 0, pready, pslverr, instr_ready, supervisor, fetch_flush, err;
    logic illegal_exc, priv_exc, mac_op, cache_enable, ea_alterable;
    logic [7:0] paddr = 0;
    logic [15:0] instr_word = 0;
    logic [31:0] pwdata = 0, instr_ext = 0, instr_pc = 0, prdata, ea_addr, rd;
    logic [3:0] ea_class;
    logic [1:0] op_size;
    int failures = 0, comparisons = 0;
    `define CHK(a, e) check(a, e)
    always #5 pclk = ~pclk;
    effective_address_decode u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .instr_valid, .instr_word, .instr_ext, .instr_pc,
        .instr_ready, .exc_entry, .supervisor, .fetch_flush, .illegal_exc, .priv_exc, .mac_op,
        .cache_enable, .ea_addr, .ea_class, .op_size, .ea_alterable);
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] a, input logic [31:0] e);
        comparisons++;
        if (a !== e) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) failures++;
        if (n >= 20) report_and_stop();
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        #1;
    endtask
    task automatic dec(input logic [15:0] w, input logic [31:0] x);
        int n;
        n = 0;
        @(posedge pclk);
        instr_valid <= 1;
        instr_word <= w;
        instr_ext <= x;
        instr_pc <= 32'h0000_2000;
        do begin
            @(posedge pclk);
            n++;
        end while (instr_ready !== 1'b1 && n < 20);
        instr_valid <= 0;
        do begin
            @(posedge pclk);
            #1;
            n++;
        end while (instr_ready !== 1'b1 && n < 40);
        if (n >= 40) failures++;
        if (n >= 40) report_and_stop();
    endtask
    task automatic ea(input logic [5:0] m, input logic [31:0] x, input logic [3:0] c,
            input logic [31:0] ad, input logic al);
        dec({10'h003, m}, x);
        `CHK(ea_class, c);
        `CHK(op_size, SZ_LONG);
        if (c != EA_IMM && c != EA_NONE && c != EA_AREG) `CHK(ea_addr, ad);
        if (c != EA_IMM && c != EA_NONE) `CHK(ea_alterable, al);
        `CHK(illegal_exc, c == EA_NONE);
    endtask
    task automatic flush_seen();
        int n;
        n = 0;
        #1;
        while (fetch_flush !== 1'b1 && n < 8) begin
            @(posedge pclk);
            #1;
            n++;
        end
        `CHK(fetch_flush, 1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        apb(0, 8'h10, 0);
        `CHK(rd, 32'h0000_2700);
        `CHK(supervisor, 1);
        apb(1, 8'h7C, 32'h0000_8000);
        apb(0, 8'h7C, 0);
        `CHK(rd, 32'h0000_8000);
        apb(1, 8'h14, 32'hFFFF_FFFF);
        apb(0, 8'h14, 0);
        `CHK(rd, 32'hFFF0_0000);
        apb(1, 8'h18, 32'h8000_0000);
        `CHK(cache_enable, 1);
        apb(1, 8'h1C, 32'h1234_5678);
        apb(0, 8'h1C, 0);
        `CHK(rd, 32'h1234_5678);
        apb(0, 8'h30, 0);
        `CHK(err, 0);
        `CHK(rd, 0);
        $display("registers done");
    endtask
    task automatic t_modes();
        apb(1, 8'h68, 32'h0000_1000);
        apb(1, 8'h44, 32'h0000_0010);
        ea(6'h03, 0, EA_DREG, 3, 1);
        ea(6'h0D, 0, EA_AREG, 0, 1);
        ea(6'h12, 0, EA_IND, 32'h1000, 1);
        ea(6'h1A, 0, EA_POSTINC, 32'h1000, 1);
        apb(0, 8'h68, 0);
        `CHK(rd, 32'h0000_1004);
        ea(6'h22, 0, EA_PREDEC, 32'h1000, 1);
        ea(6'h2A, 32'hFFFE, EA_DISP16, 32'h0FFE, 1);
        ea(6'h32, 32'h1CF0, EA_INDEX, 32'h1030, 1);
        ea(6'h3A, 32'h0010, EA_PC_DISP, 32'h2012, 0);
        ea(6'h3B, 32'h1CF0, EA_PC_INDEX, 32'h2032, 0);
        ea(6'h38, 32'h1234, EA_ABS_W, 32'h1234, 1);
        ea(6'h39, 32'h1234_5678, EA_ABS_L, 32'h1234_5678, 1);
        ea(6'h3C, 32'h5, EA_IMM, 0, 0);
        for (int i = 5; i < 8; i++) ea(6'h38 + 6'(i), 0, EA_NONE, 0, 0);
        apb(0, 8'h0C, 0);
        `CHK(rd, 32'h0000_2000);
        dec(16'hA000, 0);
        `CHK(mac_op, 1);
        `CHK(op_size, SZ_BYTE);
        dec(16'hE018, 0);
        `CHK(illegal_exc, 1);
        dec(16'h51C8, 0);
        `CHK(illegal_exc, 1);
        dec(16'h4C00, 32'h0400_0000);
        `CHK(illegal_exc, 1);
        $display("modes done");
    endtask
    task automatic t_priv();
        apb(1, 8'h10, 0);
        flush_seen();
        `CHK(supervisor, 0);
        apb(1, 8'h10, 32'h0000_27FF);
        apb(0, 8'h10, 0);
        `CHK(rd, 32'h0000_00FF);
        apb(0, 8'h14, 0);
        `CHK(err, 1);
        `CHK(rd, 0);
        apb(1, 8'h18, 0);
        `CHK(cache_enable, 1);
        dec(16'h4E72, 0);
        `CHK(priv_exc, 1);
        dec(16'h4E73, 0);
        `CHK(priv_exc, 1);
        @(posedge pclk);
        exc_entry <= 1;
        @(posedge pclk);
        exc_entry <= 0;
        #1;
        `CHK(supervisor, 1);
        apb(0, 8'h24, 0);
        `CHK(rd, 32'h0000_00FF);
        apb(0, 8'h7C, 0);
        `CHK(rd, 32'h0000_7FFC);
        dec(16'h4E73, 0);
        flush_seen();
        `CHK(supervisor, 0);
        apb(0, 8'h7C, 0);
        `CHK(rd, 32'h0000_8000);
        $display("privilege done");
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1;
        t_regs();
        t_modes();
        t_priv();
        report_and_stop();
    end
endmodule
